// ===== rtl/ldp_cfg.svh
// Timing counts, levels and codes for the LED dimming pre-boost control
`ifndef LDP_CFG_SVH
`define LDP_CFG_SVH
`define LDP_CLK_PERIOD_NS 20
`define LDP_DIM_LOSS_NS 50000
`define LDP_DIM_LOSS_CYC ((`LDP_DIM_LOSS_NS + `LDP_CLK_PERIOD_NS - 1) / `LDP_CLK_PERIOD_NS)
`define LDP_SLEEP_NS 16000000
`define LDP_SLEEP_CYC (`LDP_SLEEP_NS / `LDP_CLK_PERIOD_NS)
`define LDP_SETTLE_NS 1000000
`define LDP_SETTLE_STEP_CYC (`LDP_SETTLE_NS / (`LDP_CLK_PERIOD_NS * 256))
`define LDP_LVL_FULL 8'hFF
`define LDP_LVL_MIN 8'h1A
`define LDP_VCODE_LO 8'h0A
`define LDP_VCODE_HI 8'h66
`define LDP_AVG_PERIODS 4
`endif

// ===== rtl/ldp_pkg.sv
// Types shared by the LED dimming pre-boost control
package ldp_pkg;
  typedef enum logic [4:0] {
    LDP_ST_SLEEP = 5'b00001,
    LDP_ST_IDLE  = 5'b00010,
    LDP_ST_LEAD  = 5'b00100,
    LDP_ST_ON    = 5'b01000,
    LDP_ST_TRAIL = 5'b10000
  } ldp_state_t;

  typedef struct packed {
    logic boost_en;
    logic sinks_on;
    logic shutdown;
    logic soft_start;
  } ldp_drive_t;

  typedef struct packed {
    logic duty_dim_mode;
    logic [7:0] peak_level;
  } ldp_dim_t;
endpackage

// ===== rtl/ldp_dim_ctrl.sv
// LED dimming control: pre-boost lead delay, gate sequencing, peak level dimming
// Overview of operation
// - Boost switching starts at once when the brightness gate rises.
// - Current sinks stay off for the lead delay after a gate rise.
// - After gate falls, boost and sinks stay on for the same lead delay.
// - Lead delay comes from an external setting, not fixed.
// - Clock pulses on the dimming input select duty dimming mode.
// - In duty mode peak level is 100% minus measured high duty.
// - Duty mode falls back to voltage mode after 50 us without pulses.
// - Voltage mode maps 0.2 V to 2 V linearly onto 10% to 100%.
// - An open dimming input reads low and gives about 10%.
// - Level changes settle over roughly 1 ms instead of stepping.
// - Sinks follow the gate one lead delay late; a low shorter than the lead delay leaves them on, and a fall inside the lead delay counts from its end.
// - Gate low beyond 16 ms shuts down; next high needs a soft start.
`timescale 1ns/10ps
`include "ldp_cfg.svh"

module ldp_dim_ctrl #(
  parameter int DLY_W = 10,
  parameter int SLEEP_CYC = `LDP_SLEEP_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Pins
  input wire logic gate_in,
  input wire logic dim_clk_in,
  // Same-domain inputs
  input wire logic [DLY_W-1:0] lead_delay_setting,
  input wire logic [7:0] peak_dim_input,
  // Outputs
  output ldp_pkg::ldp_drive_t drive_o,
  output ldp_pkg::ldp_dim_t dim_o
);
  import ldp_pkg::*;

  localparam int LOSS_CYC = `LDP_DIM_LOSS_CYC;
  localparam int STEP_CYC = `LDP_SETTLE_STEP_CYC;
  localparam int AVG = `LDP_AVG_PERIODS;

  if (DLY_W < 2 || DLY_W > 16 || SLEEP_CYC < 2 || SLEEP_CYC >= (1 << 24)) begin
    $error("ldp_dim_ctrl: unsupported parameter value");
  end

  function automatic logic [7:0] volt_to_level(input logic [7:0] code);
    logic [15:0] span;
    span = 16'h0000;
    if (code <= `LDP_VCODE_LO) begin
      return `LDP_LVL_MIN;
    end
    if (code >= `LDP_VCODE_HI) begin
      return `LDP_LVL_FULL;
    end
    // Operands widened first; an eight-bit product would wrap
    span = 16'(code - `LDP_VCODE_LO) * 16'(`LDP_LVL_FULL - `LDP_LVL_MIN);
    return 8'(`LDP_LVL_MIN + span / 16'(`LDP_VCODE_HI - `LDP_VCODE_LO));
  endfunction

  // Pin synchronisers; dclk_s3 only for edge detection off the second stage
  logic gate_s1, gate_s2, dclk_s1, dclk_s2, dclk_s3;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      gate_s1 <= 1'b0;
      gate_s2 <= 1'b0;
      dclk_s1 <= 1'b0;
      dclk_s2 <= 1'b0;
      dclk_s3 <= 1'b0;
    end else begin
      gate_s1 <= gate_in;
      gate_s2 <= gate_s1;
      dclk_s1 <= dim_clk_in;
      dclk_s2 <= dclk_s1;
      dclk_s3 <= dclk_s2;
    end
  end
  logic dclk_rise;
  assign dclk_rise = dclk_s2 & ~dclk_s3;

  // Gate sequencing
  ldp_state_t st_r;
  logic [DLY_W-1:0] dly_cnt_r;
  logic [23:0] sleep_cnt_r;
  ldp_drive_t drive_r;
  logic [DLY_W-1:0] dly_load;
  // Zero setting still gives one cycle of lead
  assign dly_load = (lead_delay_setting == '0) ? DLY_W'(1) : lead_delay_setting;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r <= LDP_ST_SLEEP;
      dly_cnt_r <= '0;
      sleep_cnt_r <= '0;
      drive_r <= '{boost_en: 1'b0, sinks_on: 1'b0, shutdown: 1'b1, soft_start: 1'b0};
    end else begin
      drive_r.soft_start <= 1'b0;
      unique case (st_r)
        LDP_ST_SLEEP: begin
          if (gate_s2) begin
            st_r <= LDP_ST_LEAD;
            dly_cnt_r <= dly_load;
            drive_r.shutdown <= 1'b0;
            drive_r.soft_start <= 1'b1;
            drive_r.boost_en <= 1'b1;
          end
        end
        LDP_ST_IDLE: begin
          drive_r.sinks_on <= 1'b0;
          if (gate_s2) begin
            st_r <= LDP_ST_LEAD;
            dly_cnt_r <= dly_load;
            drive_r.boost_en <= 1'b1;
          end else if (sleep_cnt_r >= 24'(SLEEP_CYC - 1)) begin
            st_r <= LDP_ST_SLEEP;
            drive_r.shutdown <= 1'b1;
          end else begin
            sleep_cnt_r <= sleep_cnt_r + 24'h000001;
          end
        end
        LDP_ST_LEAD: begin
          if (dly_cnt_r == DLY_W'(1)) begin
            st_r <= LDP_ST_ON;
            drive_r.sinks_on <= 1'b1;
          end else begin
            dly_cnt_r <= dly_cnt_r - DLY_W'(1);
          end
        end
        LDP_ST_ON: begin
          if (!gate_s2) begin
            st_r <= LDP_ST_TRAIL;
            dly_cnt_r <= dly_load;
          end
        end
        LDP_ST_TRAIL: begin
          // A gate rise during the tail rejoins ON; the short low is absorbed
          if (gate_s2) begin
            st_r <= LDP_ST_ON;
          end else if (dly_cnt_r == DLY_W'(1)) begin
            st_r <= LDP_ST_IDLE;
            sleep_cnt_r <= '0;
            drive_r.boost_en <= 1'b0;
            drive_r.sinks_on <= 1'b0;
          end else begin
            dly_cnt_r <= dly_cnt_r - DLY_W'(1);
          end
        end
      endcase
    end
  end
  assign drive_o = drive_r;

  // Duty measurement: per-period ticks, summed over AVG periods
  logic [15:0] hi_cnt_r, per_cnt_r, hi_acc_r, per_acc_r;
  logic [2:0] nper_r;
  logic meas_ok_r, div_go_r;
  logic [15:0] div_num_r, div_den_r;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hi_cnt_r <= '0;
      per_cnt_r <= '0;
      hi_acc_r <= '0;
      per_acc_r <= '0;
      nper_r <= '0;
      meas_ok_r <= 1'b0;
      div_go_r <= 1'b0;
      div_num_r <= '0;
      div_den_r <= 16'h0001;
    end else begin
      div_go_r <= 1'b0;
      if (dclk_rise) begin
        hi_cnt_r <= 16'h0001;
        per_cnt_r <= 16'h0001;
        meas_ok_r <= 1'b1;
        if (meas_ok_r) begin
          if (nper_r == 3'(AVG - 1)) begin
            div_num_r <= hi_acc_r + hi_cnt_r;
            div_den_r <= per_acc_r + per_cnt_r;
            div_go_r <= 1'b1;
            hi_acc_r <= '0;
            per_acc_r <= '0;
            nper_r <= '0;
          end else begin
            hi_acc_r <= hi_acc_r + hi_cnt_r;
            per_acc_r <= per_acc_r + per_cnt_r;
            nper_r <= nper_r + 3'h1;
          end
        end
      end else if (per_cnt_r >= 16'(LOSS_CYC)) begin
        // Stale period: restart averaging at the next edge
        meas_ok_r <= 1'b0;
        hi_acc_r <= '0;
        per_acc_r <= '0;
        nper_r <= '0;
      end else begin
        per_cnt_r <= per_cnt_r + 16'h0001;
        if (dclk_s2) begin
          hi_cnt_r <= hi_cnt_r + 16'h0001;
        end
      end
    end
  end

  // Serial divider: quotient = 256 * high / period
  logic [16:0] rem_r;
  logic [7:0] quo_r, duty_tgt_r;
  logic [3:0] div_step_r;
  logic [16:0] rem_sh;
  assign rem_sh = {rem_r[15:0], 1'b0};
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rem_r <= '0;
      quo_r <= '0;
      div_step_r <= '0;
      duty_tgt_r <= `LDP_LVL_FULL;
    end else if (div_go_r) begin
      rem_r <= {1'b0, div_num_r};
      quo_r <= '0;
      div_step_r <= 4'h8;
    end else if (div_step_r != 4'h0) begin
      div_step_r <= div_step_r - 4'h1;
      if (rem_sh >= {1'b0, div_den_r}) begin
        rem_r <= rem_sh - {1'b0, div_den_r};
        quo_r <= {quo_r[6:0], 1'b1};
      end else begin
        rem_r <= rem_sh;
        quo_r <= {quo_r[6:0], 1'b0};
      end
    end else if (div_step_r == 4'h0 && quo_r != 8'h00) begin
      duty_tgt_r <= `LDP_LVL_FULL - quo_r;
    end
  end

  // Mode select and clock loss timeout
  logic duty_mode_r;
  logic [11:0] loss_cnt_r;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      duty_mode_r <= 1'b0;
      loss_cnt_r <= '0;
    end else if (dclk_rise) begin
      duty_mode_r <= 1'b1;
      loss_cnt_r <= '0;
    end else if (duty_mode_r) begin
      if (loss_cnt_r >= 12'(LOSS_CYC - 1)) begin
        duty_mode_r <= 1'b0;
        loss_cnt_r <= '0;
      end else begin
        loss_cnt_r <= loss_cnt_r + 12'h001;
      end
    end
  end

  // Level slews one step per STEP_CYC, so a full swing takes about 1 ms
  logic [7:0] target, level_r;
  logic [7:0] step_cnt_r;
  // Open pin reads as low code, which clamps to the floor level
  assign target = duty_mode_r ? duty_tgt_r : volt_to_level(peak_dim_input);
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      level_r <= `LDP_LVL_MIN;
      step_cnt_r <= '0;
    end else if (step_cnt_r >= 8'(STEP_CYC - 1)) begin
      step_cnt_r <= '0;
      if (level_r < target) begin
        level_r <= level_r + 8'h01;
      end else if (level_r > target) begin
        level_r <= level_r - 8'h01;
      end
    end else begin
      step_cnt_r <= step_cnt_r + 8'h01;
    end
  end
  assign dim_o = '{duty_dim_mode: duty_mode_r, peak_level: level_r};

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_boost_on_rise: assert property ((st_r == LDP_ST_IDLE || st_r == LDP_ST_SLEEP) && gate_s2
    |=> drive_r.boost_en && !drive_r.sinks_on) else $error("boost not started on gate rise");
  a_sink_lead_wait: assert property ($rose(drive_r.sinks_on)
    |-> $past(st_r) == LDP_ST_LEAD && $past(dly_cnt_r) == DLY_W'(1))
    else $error("sinks enabled before lead delay");
  a_trail_hold_on: assert property (st_r == LDP_ST_ON && !gate_s2
    |=> drive_r.sinks_on && drive_r.boost_en && dly_cnt_r == $past(dly_load))
    else $error("trail delay not held");
  a_sinks_gate_low: assert property (st_r == LDP_ST_IDLE |=> !drive_r.sinks_on)
    else $error("sinks on while idle");
  a_sleep_shutdown: assert property (st_r == LDP_ST_SLEEP |-> drive_r.shutdown
    && !drive_r.boost_en) else $error("sleep without shutdown");
  a_duty_mode_entry: assert property (dclk_rise |=> duty_mode_r && loss_cnt_r == 12'h000)
    else $error("duty mode not entered");
  a_duty_mode_loss: assert property (duty_mode_r && !dclk_rise
    && loss_cnt_r == 12'(LOSS_CYC - 1) |=> !duty_mode_r) else $error("clock loss missed");
  a_duty_target: assert property (div_step_r == 4'h1 ##1 quo_r != 8'h00
    |=> duty_tgt_r == `LDP_LVL_FULL - $past(quo_r)) else $error("duty target wrong");
  a_level_slew: assert property ($changed(level_r) |-> $past(step_cnt_r) == 8'(STEP_CYC - 1)
    && (level_r == $past(level_r) + 8'h01 || level_r == $past(level_r) - 8'h01))
    else $error("level stepped too fast");
  a_volt_floor: assert property (!duty_mode_r && peak_dim_input <= `LDP_VCODE_LO
    |-> target == `LDP_LVL_MIN) else $error("open input not at floor");

  c_gate_pulse: cover property (st_r == LDP_ST_LEAD ##[1:1000] st_r == LDP_ST_TRAIL
    ##[1:1000] st_r == LDP_ST_IDLE);
  c_duty_mode: cover property ($rose(duty_mode_r));
  c_sleep: cover property (st_r == LDP_ST_IDLE ##1 st_r == LDP_ST_SLEEP);
endmodule

// ===== dv/ldp_host_model.sv
// Host model driving the brightness gate and the dimming clock
`timescale 1ns/10ps

module ldp_host_model (
  // Clock
  input wire logic core_clk,
  // Commands from the bench
  input wire logic gate_req,
  input wire logic dclk_en,
  input wire logic [7:0] dclk_hi,
  input wire logic [7:0] dclk_per,
  // Pins
  output logic gate_in,
  output logic dim_clk_in
);
  int low_cnt;
  int ph;
  logic req_q;
  logic en_q;

  initial begin
    gate_in = 1'b0;
    dim_clk_in = 1'b0;
    low_cnt = 50;
    ph = 0;
  end

  always @(posedge core_clk) begin
    // Commands taken at the edge, so bench writes just after it cannot race
    req_q = gate_req;
    en_q = dclk_en;
    #1;
    // Rise held back until the gate has been low for 1 us
    if (req_q && low_cnt >= 50) begin
      gate_in = 1'b1;
    end else if (!req_q) begin
      gate_in = 1'b0;
    end
    low_cnt = gate_in ? 0 : (low_cnt < 50 ? low_cnt + 1 : 50);
    // Bench keeps phases above 150 ns and rate inside 40 kHz to 1 MHz
    if (en_q) begin
      ph = (ph + 1 >= dclk_per) ? 0 : ph + 1;
      dim_clk_in = (ph < dclk_hi);
    end else begin
      // Pin pulled down when no clock is sent
      ph = 0;
      dim_clk_in = 1'b0;
    end
  end
endmodule

// ===== dv/tb.sv
// Testbench for the LED dimming pre-boost control
`timescale 1ns/10ps

module tb;
  import ldp_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic gate_req = 1'b0;
  logic dclk_en = 1'b0;
  logic [7:0] dclk_hi = 8'h19;
  logic [7:0] dclk_per = 8'h64;
  logic gate_in;
  logic dim_clk_in;
  logic [9:0] lead_delay_setting = 10'h004;
  logic [7:0] peak_dim_input = 8'h00;
  ldp_drive_t drive_o;
  ldp_dim_t dim_o;
  int fail_count = 0;
  int checks_done = 0;

  ldp_dim_ctrl #(.DLY_W(10), .SLEEP_CYC(200)) u_ldp_dim_ctrl (
    .core_clk(core_clk), .sys_rst(sys_rst), .gate_in(gate_in), .dim_clk_in(dim_clk_in),
    .lead_delay_setting(lead_delay_setting), .peak_dim_input(peak_dim_input),
    .drive_o(drive_o), .dim_o(dim_o));

  ldp_host_model u_ldp_host_model (
    .core_clk(core_clk), .gate_req(gate_req), .dclk_en(dclk_en), .dclk_hi(dclk_hi),
    .dclk_per(dclk_per), .gate_in(gate_in), .dim_clk_in(dim_clk_in));

  initial begin
    forever #10 core_clk = ~core_clk;
  end

  task automatic stop_test();
    if (fail_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: flag got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic check_lvl(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: level got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask

  // Lag to boost on rise, D more to sinks, fall lag equals rise lag plus D
  task automatic test_lead(input logic [9:0] d, input logic exp_soft);
    int ed;
    int lag;
    int n;
    ed = (d == 10'h000) ? 1 : d;
    @(posedge core_clk);
    #1 lead_delay_setting = d;
    gate_req = 1'b1;
    lag = 0;
    do begin tick(); lag++; end while (drive_o.boost_en !== 1'b1 && lag < 6);
    check_bit(drive_o.boost_en, 1'b1);
    check_bit(drive_o.soft_start, exp_soft);
    check_bit(drive_o.shutdown, 1'b0);
    check_bit(drive_o.sinks_on, 1'b0);
    repeat (ed - 1) tick();
    check_bit(drive_o.sinks_on, 1'b0);
    tick();
    check_bit(drive_o.sinks_on, 1'b1);
    repeat (30) tick();
    @(posedge core_clk);
    #1 gate_req = 1'b0;
    n = 0;
    do begin
      tick();
      n++;
      check_bit(drive_o.sinks_on, drive_o.boost_en);
    end while (drive_o.boost_en !== 1'b0 && n < 1100);
    check_bit(n == lag + ed, 1'b1);
    // Gate kept low long enough that the next rise is not held back
    repeat (50) tick();
  endtask

  task automatic test_sleep();
    repeat (149) tick();
    check_bit(drive_o.shutdown, 1'b0);
    tick();
    check_bit(drive_o.shutdown, 1'b1);
  endtask

  task automatic wait_level(input logic [7:0] v, input int lim);
    int n;
    n = 0;
    while (dim_o.peak_level !== v && n < lim) begin tick(); n++; end
    check_lvl(dim_o.peak_level, v);
  endtask

  // Voltage ramp slews, duty clock sets 100 % minus 25 %, loss falls back
  task automatic test_dim();
    int n;
    check_lvl(dim_o.peak_level, 8'h1A);
    peak_dim_input = 8'h66;
    repeat (100) tick();
    check_bit(dim_o.peak_level < 8'h20, 1'b1);
    wait_level(8'hFF, 46000);
    dclk_en = 1'b1;
    n = 0;
    while (dim_o.duty_dim_mode !== 1'b1 && n < 120) begin tick(); n++; end
    check_bit(dim_o.duty_dim_mode, 1'b1);
    wait_level(8'hBF, 14000);
    // Mid-scale code: level halfway between floor and full
    peak_dim_input = 8'h38;
    dclk_en = 1'b0;
    repeat (2300) tick();
    check_bit(dim_o.duty_dim_mode, 1'b1);
    repeat (300) tick();
    check_bit(dim_o.duty_dim_mode, 1'b0);
    repeat (2000) tick();
    check_bit(dim_o.peak_level < 8'hBF, 1'b1);
    wait_level(8'h8C, 10000);
  endtask

  initial begin
    repeat (12) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    #1;
    check_bit(drive_o.shutdown, 1'b1);
    check_bit(dim_o.duty_dim_mode, 1'b0);
    test_lead(10'h004, 1'b1);
    test_lead(10'h014, 1'b0);
    test_sleep();
    test_lead(10'h000, 1'b1);
    test_dim();
    stop_test();
  end

  initial begin
    repeat (90000) @(posedge core_clk);
    fail_count++;
    stop_test();
  end
endmodule
